/* File: hdl/bit_modify_pkg.sv */
// Package with encodings, field layouts and timing counts for the single-bit modify unit.
package bit_modify_pkg;
	localparam logic [7:0] OPC_BIT_COMPLEMENT = 8'h57;
	localparam logic [7:0] OPC_BIT_CLEAR_SET = 8'h77;
	localparam logic [7:0] FLAGS_REG_ADDR = 8'hd5;
	localparam int REG_NUM_MSB = 7;
	localparam int REG_NUM_LSB = 4;
	localparam int BIT_IDX_MSB = 3;
	localparam int BIT_IDX_LSB = 1;
	localparam int SEL_POS = 0;
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] REG_RESET = 4'h0;
	localparam logic [2:0] CYCLES_BIT_MODIFY = 3'h4;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
	} instr_t;

	typedef struct packed {
		logic [3:0] regNum;
		logic [7:0] data;
		logic [7:0] flags;
		logic flagsWrite;
	} result_t;
endpackage : bit_modify_pkg

/* File: hdl/single_bit_modify_unit.sv */
// Single-bit complement, clear and set datapath with its flag update.
`timescale 1ns/1ps
module single_bit_modify_unit (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire bit_modify_pkg::instr_t instr,
	input wire logic [7:0] regData,
	input wire logic [7:0] flagsIn,
	output logic [3:0] regAddr,
	output logic [7:0] flagsAddr,
	output logic busy,
	output logic done,
	output bit_modify_pkg::result_t result
);
	// ==========================================================
	// Decode
	logic isCompl;
	logic isClrSet;
	logic [3:0] dstReg;
	logic [2:0] bitIdx;
	logic selSet;
	logic [2:0] count;
	logic [2:0] heldIdx;
	logic heldCompl;
	logic heldSet;

	function automatic logic [7:0] one_hot(input logic [2:0] idx);
		one_hot = 8'h01 << idx;
	endfunction : one_hot

	assign isCompl = instr.opcode == bit_modify_pkg::OPC_BIT_COMPLEMENT;
	assign isClrSet = instr.opcode == bit_modify_pkg::OPC_BIT_CLEAR_SET;
	assign dstReg = instr.operand[bit_modify_pkg::REG_NUM_MSB:bit_modify_pkg::REG_NUM_LSB];
	assign bitIdx = instr.operand[bit_modify_pkg::BIT_IDX_MSB:bit_modify_pkg::BIT_IDX_LSB];
	assign selSet = instr.operand[bit_modify_pkg::SEL_POS];

	// ==========================================================
	// Sequencing
	// A request is taken only while idle, so a start that arrives during the three busy cycles is dropped.
	// The operand fields are latched at the taking edge so the decoder may move on at once.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 3'h0;
			busy <= 1'b0;
			regAddr <= bit_modify_pkg::REG_RESET;
			heldIdx <= 3'h0;
			heldCompl <= 1'b0;
			heldSet <= 1'b0;
		end else if (!busy && start && (isCompl || isClrSet)) begin
			count <= bit_modify_pkg::CYCLES_BIT_MODIFY - 3'h1;
			busy <= 1'b1;
			regAddr <= dstReg;
			heldIdx <= bitIdx;
			heldCompl <= isCompl;
			heldSet <= selSet;
		end else if (busy) begin
			count <= count - 3'h1;
			busy <= count != 3'h1;
		end
	end

	// The flags register location is fixed, so it is driven from the first edge after reset.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flagsAddr <= bit_modify_pkg::FLAGS_RESET;
		end else begin
			flagsAddr <= bit_modify_pkg::FLAGS_REG_ADDR;
		end
	end

	// ==========================================================
	// Result and flags
	logic [7:0] newData;
	logic [7:0] newFlags;
	// Flags start as a copy of the current value, so carry, decimal-adjust and half-carry are kept.
	// The overflow flag is undefined after a complement and is simply passed through.
	always_comb begin
		newFlags = flagsIn;
		if (heldCompl) begin
			newData = regData ^ one_hot(heldIdx);
			newFlags[bit_modify_pkg::FLAG_Z] = newData == 8'h00;
			newFlags[bit_modify_pkg::FLAG_S] = 1'b0;
		end else if (heldSet) begin
			newData = regData | one_hot(heldIdx);
		end else begin
			newData = regData & ~one_hot(heldIdx);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			done <= 1'b0;
			result <= '0;
		end else if (busy && count == 3'h1) begin
			done <= 1'b1;
			result.regNum <= regAddr;
			result.data <= newData;
			result.flags <= newFlags;
			result.flagsWrite <= heldCompl;
		end else begin
			done <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	// A request that the unit takes.
	sequence s_accept;
		!busy && start && (isCompl || isClrSet);
	endsequence

	// A request with an opcode that the unit does not handle.
	sequence s_foreign;
		!busy && start && !(isCompl || isClrSet);
	endsequence

	// Three busy cycles, then the cycle that carries the result.
	sequence s_busy_window;
		busy[*3] ##1 (!busy && done);
	endsequence

	// The done pulse lasts a single cycle.
	sequence s_done_pulse;
		done ##1 !done;
	endsequence

	a_done_timing: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_accept |-> ##4 done)
		else $error("done not four cycles after accept");

	a_busy_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_accept |=> s_busy_window)
		else $error("busy not held three cycles");

	a_done_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_accept |-> ##4 s_done_pulse)
		else $error("done pulse longer than one cycle");

	a_foreign_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_foreign |=> !busy)
		else $error("foreign opcode was taken");

	a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		busy && start |=> $stable(regAddr))
		else $error("request taken while busy");

	a_idle_no_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!busy |=> !done)
		else $error("done without a running request");

	a_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && !result.flagsWrite |-> result.flags == $past(flagsIn))
		else $error("clear or set changed flags");

	a_zero_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && result.flagsWrite |-> result.flags[bit_modify_pkg::FLAG_Z] == (result.data == 8'h00))
		else $error("zero flag wrong");

	a_sign_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && result.flagsWrite |-> !result.flags[bit_modify_pkg::FLAG_S])
		else $error("sign flag not cleared");

	a_carry_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && result.flagsWrite |->
		result.flags[bit_modify_pkg::FLAG_C] == $past(flagsIn[bit_modify_pkg::FLAG_C]) &&
		result.flags[bit_modify_pkg::FLAG_D] == $past(flagsIn[bit_modify_pkg::FLAG_D]) &&
		result.flags[bit_modify_pkg::FLAG_H] == $past(flagsIn[bit_modify_pkg::FLAG_H]))
		else $error("carry, decimal or half-carry flag changed");

	a_other_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done |-> ((result.data ^ $past(regData)) & ~one_hot($past(heldIdx))) == 8'h00)
		else $error("unaddressed bit changed");

	a_compl_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && result.flagsWrite |-> (result.data ^ $past(regData)) == one_hot($past(heldIdx)))
		else $error("complement bit not flipped");

	a_set_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done && !result.flagsWrite |-> result.data[$past(heldIdx)] == $past(heldSet))
		else $error("clear or set bit wrong");

	a_reg_field: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_accept |=> regAddr == $past(instr.operand[7:4]))
		else $error("register number wrong");

	a_result_reg: assert property (@(posedge sys_clk) disable iff (!rst_b)
		done |-> result.regNum == $past(regAddr))
		else $error("result register number wrong");

	a_idx_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
		busy |=> $stable(heldIdx))
		else $error("bit index changed while busy");

	a_flags_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
		busy |-> flagsAddr == bit_modify_pkg::FLAGS_REG_ADDR)
		else $error("flags address wrong");
endmodule : single_bit_modify_unit

/* File: verif/test_single_bit_modify_unit.sv */
// Self-checking testbench for the single-bit modify unit.
`timescale 1ns/1ps
module test_single_bit_modify_unit;
	logic sys_clk = 1'b0;
	logic rst_b;
	logic start;
	bit_modify_pkg::instr_t instr;
	logic [7:0] regData;
	logic [7:0] flagsIn;
	logic [3:0] regAddr;
	logic [7:0] flagsAddr;
	logic busy;
	logic done;
	bit_modify_pkg::result_t result;
	bit_modify_pkg::result_t expQ[$];
	int fail_count = 0;
	int check_count = 0;
	int seed = 85;
	logic [7:0] opd;
	logic [7:0] val;
	logic [7:0] flg;
	logic [7:0] opc;

	single_bit_modify_unit i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .start(start), .instr(instr),
		.regData(regData), .flagsIn(flagsIn), .regAddr(regAddr), .flagsAddr(flagsAddr), .busy(busy),
		.done(done), .result(result));

	always #5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [20:0] expv, input logic [20:0] seen);
		check_count++;
		if (seen !== expv) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	task automatic test_done();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	// Drives one request, notes the expected result and keeps operands steady until it lands.
	// With hold set, start stays high through the busy cycles, where the unit must ignore it.
	task automatic issue(input logic [7:0] code, input logic [7:0] opnd, input logic [7:0] v, input logic [7:0] f,
		input logic hold);
		bit_modify_pkg::result_t e;
		logic ok;
		ok = (code == bit_modify_pkg::OPC_BIT_COMPLEMENT) || (code == bit_modify_pkg::OPC_BIT_CLEAR_SET);
		e.regNum = opnd[7:4];
		e.data = v;
		e.data[opnd[3:1]] = (code == bit_modify_pkg::OPC_BIT_COMPLEMENT) ? ~v[opnd[3:1]] : opnd[0];
		e.flags = f;
		e.flagsWrite = (code == bit_modify_pkg::OPC_BIT_COMPLEMENT);
		if (e.flagsWrite) begin
			e.flags[bit_modify_pkg::FLAG_Z] = (e.data == 8'h00);
			e.flags[bit_modify_pkg::FLAG_S] = 1'b0;
		end
		if (ok) expQ.push_back(e);
		start = 1'b1;
		instr = {code, opnd};
		regData = v;
		flagsIn = f;
		@(posedge sys_clk);
		#1;
		if (!hold) start = 1'b0;
		if (ok) check("register address", 21'(opnd[7:4]), 21'(regAddr));
		if (ok) check("busy raised", 21'h000001, 21'(busy));
		repeat (3) @(posedge sys_clk);
		#1 start = 1'b0;
		@(posedge sys_clk);
		#1 check("busy dropped", 21'h000000, 21'(busy));
	endtask : issue

	always @(posedge sys_clk) begin
		if (done === 1'b1) begin
			if (expQ.size() == 0) check("unexpected done", 21'h000000, 21'h1fffff);
			else check("result", expQ.pop_front(), result);
		end
	end

	initial begin
		#20000 fail_count++;
		test_done();
	end

	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		instr = '0;
		regData = 8'h00;
		flagsIn = 8'h00;
		repeat (8) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		@(posedge sys_clk);
		#1 check("flags address", 21'(bit_modify_pkg::FLAGS_REG_ADDR), 21'(flagsAddr));
		for (int i = 0; i < 60; i++) begin
			opd = 8'($random(seed));
			val = 8'($random(seed));
			flg = 8'($random(seed));
			opc = (i % 3 == 0) ? bit_modify_pkg::OPC_BIT_COMPLEMENT : bit_modify_pkg::OPC_BIT_CLEAR_SET;
			// A lone set bit that gets complemented leaves a zero result.
			if (i % 5 == 0) val = 8'h01 << opd[3:1];
			issue(opc, opd, val, flg, i[0]);
		end
		issue(8'h12, 8'h35, 8'h0f, 8'hff, 1'b1);
		repeat (6) @(posedge sys_clk);
		check("pending results", 21'h000000, 21'(expQ.size()));
		test_done();
	end
endmodule : test_single_bit_modify_unit
